//--- hdl/ncoddc_pkg.sv
// Package: register map, field positions and reset values of the NCO/DDC controls
package ncoddc_pkg;
    localparam logic [9:0] OFS_LOAD_MODE   = 10'h164;
    localparam logic [9:0] OFS_SRC_BYPASS  = 10'h165;
    localparam logic [9:0] OFS_FREQ_CHOICE = 10'h166;
    localparam logic [9:0] OFS_DECIM_LOW   = 10'h167;
    localparam logic [9:0] OFS_DECIM_HIGH  = 10'h168;
    localparam logic [7:0] RST_LOAD_MODE   = 8'h00;
    localparam logic [7:0] RST_SRC_BYPASS  = 8'h00;
    localparam logic [7:0] RST_FREQ_CHOICE = 8'h00;
    localparam logic [7:0] RST_DECIM       = 8'h00;
    localparam int BIT_OSC_LOAD_LSB   = 4;
    localparam int BIT_NEG_IMAGE      = 3;
    localparam int BIT_PHASE_MODE     = 0;
    localparam int BIT_FAST_PATH      = 4;
    localparam int BIT_AUTOLOAD_INH   = 2;
    localparam int BIT_SEL_SOURCE     = 1;
    localparam int BIT_GLOBAL_LOAD    = 0;
    localparam logic [7:0] MASK_LOAD_MODE  = 8'hf9;
    localparam logic [7:0] MASK_SRC_BYPASS = 8'h17;
    localparam int N_OSC    = 4;
    localparam int FREQ_W   = 48;
    localparam int PHASE_W  = 16;
    localparam int WORD_SEL = 4;
endpackage : ncoddc_pkg

//--- hdl/ncoddc_ctrl.sv
// NCO/DDC selection, load and decimation control register bank
`timescale 1ns/1ns
module ncoddc_ctrl
    import ncoddc_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    input  wire logic [9:0]                 reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    output logic      [7:0]                 reg_rdata,
    output logic                            reg_hit,
    input  wire logic [7:0]                 pin_freq_sel,
    input  wire logic                       complex_conversion_enable,
    input  wire logic                       unequal_decim_enable,
    input  wire logic [3:0]                 common_decim_factor,
    input  wire logic [N_OSC*WORD_SEL*FREQ_W-1:0]  prog_freq,
    input  wire logic [N_OSC*WORD_SEL*PHASE_W-1:0] prog_phase,
    output logic [N_OSC*WORD_SEL*FREQ_W-1:0]  live_freq,
    output logic [N_OSC*WORD_SEL*PHASE_W-1:0] live_phase,
    output logic      [7:0]                 active_freq_choice,
    output logic                            phase_coherent_mode,
    output logic                            negative_image_pick,
    output logic                            complex_decim_mode,
    output logic                            fast_path_bypass,
    output logic      [3:0]                 conv_decim_code [N_OSC],
    output logic      [15:0]                conv_decim_ratio [N_OSC]
);

    localparam int OSC_F = WORD_SEL * FREQ_W;
    localparam int OSC_P = WORD_SEL * PHASE_W;

    logic [7:0] load_mode_reg;
    logic [7:0] src_bypass_reg;
    logic [7:0] freq_choice_reg;
    logic [7:0] decim_low_reg;
    logic [7:0] decim_high_reg;
    logic [7:0] pin_sel_reg;
    logic [N_OSC-1:0] osc_load_next;
    logic       global_load_next;
    logic       pin_switch_next;

    ////////////////////////////////////////////////////////////////////////
    // Ratio decode, 0 means bypass
    function automatic logic [15:0] ncoddc_ratio(input logic [3:0] code);
        logic [15:0] r;
        r = 16'h0000;
        if (code != 4'h0) begin
            r = 16'h0001 << code;
        end
        return r;
    endfunction : ncoddc_ratio

    // Active decimation code of one converter
    function automatic logic [3:0] ncoddc_code(input int idx);
        logic [7:0] pair;
        pair = (idx < 2) ? decim_low_reg : decim_high_reg;
        if (!unequal_decim_enable) begin
            return common_decim_factor;
        end
        return pair[(idx%2)*4 +: 4];
    endfunction : ncoddc_code

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_mode_reg   <= RST_LOAD_MODE;
            src_bypass_reg  <= RST_SRC_BYPASS;
            freq_choice_reg <= RST_FREQ_CHOICE;
            decim_low_reg   <= RST_DECIM;
            decim_high_reg  <= RST_DECIM;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFS_LOAD_MODE:   load_mode_reg   <= reg_wdata & MASK_LOAD_MODE;
                OFS_SRC_BYPASS:  src_bypass_reg  <= reg_wdata & MASK_SRC_BYPASS;
                OFS_FREQ_CHOICE: freq_choice_reg <= reg_wdata;
                OFS_DECIM_LOW:   decim_low_reg   <= reg_wdata;
                OFS_DECIM_HIGH:  decim_high_reg  <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register reads, unmapped reads zero
    always_comb begin
        reg_hit = 1'b1;
        unique case (reg_addr)
            OFS_LOAD_MODE:   reg_rdata = load_mode_reg;
            OFS_SRC_BYPASS:  reg_rdata = src_bypass_reg;
            OFS_FREQ_CHOICE: reg_rdata = freq_choice_reg;
            OFS_DECIM_LOW:   reg_rdata = decim_low_reg;
            OFS_DECIM_HIGH:  reg_rdata = decim_high_reg;
            default: begin
                reg_rdata = 8'h00;
                reg_hit   = 1'b0;
            end
        endcase
        if (!reg_rd) begin
            reg_rdata = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Load edge detection against stored bits
    always_comb begin
        osc_load_next = '0;
        global_load_next = 1'b0;
        if (reg_wr && reg_addr == OFS_LOAD_MODE) begin
            for (int i = 0; i < N_OSC; i++) begin
                osc_load_next[i] = reg_wdata[BIT_OSC_LOAD_LSB+i] &
                    ~load_mode_reg[BIT_OSC_LOAD_LSB+i];
            end
        end
        if (reg_wr && reg_addr == OFS_SRC_BYPASS) begin
            global_load_next = reg_wdata[BIT_GLOBAL_LOAD] &
                ~src_bypass_reg[BIT_GLOBAL_LOAD];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_sel_reg <= 8'h00;
        end else begin
            pin_sel_reg <= pin_freq_sel;
        end
    end

    assign pin_switch_next = ~src_bypass_reg[BIT_SEL_SOURCE] &
        ~src_bypass_reg[BIT_AUTOLOAD_INH] &
        (pin_sel_reg != pin_freq_sel);

    ////////////////////////////////////////////////////////////////////////
    // Live frequency and phase words
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            live_freq  <= '0;
            live_phase <= '0;
        end else begin
            for (int i = 0; i < N_OSC; i++) begin
                if (osc_load_next[i] || global_load_next ||
                    pin_switch_next) begin
                    live_freq[i*OSC_F +: OSC_F] <=
                        prog_freq[i*OSC_F +: OSC_F];
                    live_phase[i*OSC_P +: OSC_P] <=
                        prog_phase[i*OSC_P +: OSC_P];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Active selection and mode outputs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            active_freq_choice <= 8'h00;
        end else if (src_bypass_reg[BIT_SEL_SOURCE]) begin
            active_freq_choice <= freq_choice_reg;
        end else if (!src_bypass_reg[BIT_AUTOLOAD_INH]) begin
            active_freq_choice <= pin_freq_sel;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_coherent_mode <= 1'b0;
            negative_image_pick <= 1'b0;
            complex_decim_mode  <= 1'b0;
            fast_path_bypass    <= 1'b0;
        end else begin
            phase_coherent_mode <= load_mode_reg[BIT_PHASE_MODE];
            negative_image_pick <= load_mode_reg[BIT_NEG_IMAGE] &
                complex_conversion_enable;
            complex_decim_mode  <= complex_conversion_enable;
            fast_path_bypass    <= src_bypass_reg[BIT_FAST_PATH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decimation factor per converter
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < N_OSC; i++) begin
                conv_decim_code[i]  <= 4'h0;
                conv_decim_ratio[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < N_OSC; i++) begin
                conv_decim_code[i]  <= ncoddc_code(i);
                conv_decim_ratio[i] <= ncoddc_ratio(ncoddc_code(i));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_osc_load;
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr && reg_addr == OFS_LOAD_MODE && reg_wdata[4] &&
         !load_mode_reg[4]) |=>
        live_freq[OSC_F-1:0] == $past(prog_freq[OSC_F-1:0]);
    endproperty
    a_osc_load: assert property (p_osc_load)
        else $error("osc0 load missed");

    property p_neg_img;
        @(posedge sys_clk) disable iff (sys_rst)
        !complex_conversion_enable |=> !negative_image_pick;
    endproperty
    a_neg_img: assert property (p_neg_img)
        else $error("negative image outside complex mode");

    property p_phase_mode;
        @(posedge sys_clk) disable iff (sys_rst)
        1'b1 |=> phase_coherent_mode == $past(load_mode_reg[0]);
    endproperty
    a_phase_mode: assert property (p_phase_mode)
        else $error("phase mode mismatch");

    property p_fast_path;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(src_bypass_reg[4]) |-> ##[0:1] fast_path_bypass;
    endproperty
    a_fast_path: assert property (p_fast_path)
        else $error("fast path not set");

    property p_inhibit;
        @(posedge sys_clk) disable iff (sys_rst)
        (src_bypass_reg[2] && !src_bypass_reg[1] && !global_load_next &&
         osc_load_next == '0) |=> $stable(live_freq);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("pin switch loaded while inhibited");

    property p_reg_sel;
        @(posedge sys_clk) disable iff (sys_rst)
        src_bypass_reg[1] |=> active_freq_choice == $past(freq_choice_reg);
    endproperty
    a_reg_sel: assert property (p_reg_sel)
        else $error("register choice not applied");

    property p_global;
        @(posedge sys_clk) disable iff (sys_rst)
        global_load_next |=> live_freq == $past(prog_freq);
    endproperty
    a_global: assert property (p_global)
        else $error("global load missed");

    property p_ratio;
        @(posedge sys_clk) disable iff (sys_rst)
        (conv_decim_code[0] == 4'hf) |-> conv_decim_ratio[0] == 16'h8000;
    endproperty
    a_ratio: assert property (p_ratio)
        else $error("ratio decode wrong");

    property p_common;
        @(posedge sys_clk) disable iff (sys_rst)
        !unequal_decim_enable |=>
        conv_decim_code[3] == $past(common_decim_factor);
    endproperty
    a_common: assert property (p_common)
        else $error("common factor not applied");

endmodule : ncoddc_ctrl

//--- verification/ncoddc_ctrl_bench.sv
// Self-checking bench for the NCO/DDC control register bank
`timescale 1ns/1ns
module ncoddc_ctrl_bench
    import ncoddc_pkg::*;
;
    typedef struct {string nm; int sel; logic [767:0] exp;} ncoddc_note_t;
    logic         sys_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [9:0]   reg_addr = '0;
    logic [7:0]   reg_wdata = '0;
    logic [7:0]   reg_rdata;
    logic         reg_hit;
    logic [7:0]   pin_freq_sel = '0;
    logic         complex_conversion_enable = 1'b0;
    logic         unequal_decim_enable = 1'b0;
    logic [3:0]   common_decim_factor = '0;
    logic [767:0] prog_freq = '0;
    logic [255:0] prog_phase = '0;
    logic [767:0] live_freq;
    logic [255:0] live_phase;
    logic [7:0]   active_freq_choice;
    logic         phase_coherent_mode;
    logic         negative_image_pick;
    logic         complex_decim_mode;
    logic         fast_path_bypass;
    logic [3:0]   conv_decim_code [N_OSC];
    logic [15:0]  conv_decim_ratio [N_OSC];
    logic [767:0] exp_f = '0;
    logic [255:0] exp_p = '0;
    logic [7:0]   v;
    logic [3:0]   e4;
    ncoddc_note_t notes [$];
    ncoddc_note_t cur;
    int           n_errors = 0;
    int           samples_checked = 0;
    `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
        n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
    ncoddc_ctrl ncoddc_ctrl_inst (.*);
    always #50 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [767:0] seen(int s);
        case (s)
            0: return 768'({reg_hit, reg_rdata});
            1: return live_freq;
            2: return 768'(live_phase);
            3: return 768'(active_freq_choice);
            4: return 768'({phase_coherent_mode, negative_image_pick,
                             complex_decim_mode, fast_path_bypass});
            default: return 768'({conv_decim_code[s-5], conv_decim_ratio[s-5]});
        endcase
    endfunction : seen
    function automatic logic [15:0] ratio(logic [3:0] c);
        logic [15:0] r;
        r = (c == 4'h0) ? 16'h0000 : 16'h0002;
        for (int k = 1; k < c; k++) r = r * 16'h0002;
        return r;
    endfunction : ratio
    task automatic note(string nm, int sel, logic [767:0] e);
        notes.push_back('{nm, sel, e});
    endtask : note
    task automatic step(int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task automatic wr(logic [9:0] a, logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        step(1);
        reg_wr = 1'b0;
        step(1);
    endtask : wr
    task automatic rd(logic [9:0] a, logic [8:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        note("read", 0, 768'(e));
        step(1);
        reg_rd = 1'b0;
        note("idle read", 0, 768'({e[8], 8'h00}));
        step(1);
    endtask : rd
    task automatic fill();
        for (int i = 0; i < 24; i++) prog_freq[i*32 +: 32] = $urandom;
        for (int i = 0; i < 8; i++) prog_phase[i*32 +: 32] = $urandom;
    endtask : fill
    task automatic print_verdict();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    always @(negedge sys_clk) begin
        #1;
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            `CHK(cur.nm, cur.exp, seen(cur.sel))
        end
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hb4a342e3));
        fill();
        step(6);
        sys_rst = 1'b0;
        step(1);
        for (int i = 0; i < 5; i++) rd(OFS_LOAD_MODE + 10'(i), 9'h100);
        rd(10'h169, 9'h000);
        note("live", 1, '0);
        note("modes", 4, '0);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_LOAD_MODE, 8'h10 << k);
            step(2);
            exp_f[k*192 +: 192] = prog_freq[k*192 +: 192];
            exp_p[k*64 +: 64] = prog_phase[k*64 +: 64];
            note("osc freq", 1, exp_f);
            note("osc phase", 2, 768'(exp_p));
        end
        fill();
        wr(OFS_LOAD_MODE, 8'h80);
        step(2);
        note("held load", 1, exp_f);
        wr(OFS_LOAD_MODE, 8'hff);
        step(2);
        exp_f[575:0] = prog_freq[575:0];
        note("three loads", 1, exp_f);
        rd(OFS_LOAD_MODE, 9'h1f9);
        note("modes", 4, 768'(4'b1000));
        complex_conversion_enable = 1'b1;
        step(2);
        note("modes", 4, 768'(4'b1110));
        fill();
        wr(OFS_SRC_BYPASS, 8'hff);
        step(2);
        rd(OFS_SRC_BYPASS, 9'h117);
        note("global load", 1, prog_freq);
        note("global phase", 2, 768'(prog_phase));
        note("modes", 4, 768'(4'b1111));
        wr(OFS_SRC_BYPASS, 8'h02);
        for (int k = 0; k < 4; k++) begin
            v = 8'($urandom);
            wr(OFS_FREQ_CHOICE, v);
            pin_freq_sel = ~v;
            step(2);
            note("reg choice", 3, 768'(v));
        end
        note("modes", 4, 768'(4'b1110));
        wr(OFS_SRC_BYPASS, 8'h00);
        fill();
        exp_f = prog_freq;
        v = pin_freq_sel ^ (8'($urandom) | 8'h01);
        pin_freq_sel = v;
        step(2);
        note("pin choice", 3, 768'(v));
        note("pin reload", 1, exp_f);
        wr(OFS_SRC_BYPASS, 8'h04);
        fill();
        pin_freq_sel = ~v;
        step(2);
        note("frozen choice", 3, 768'(v));
        note("no reload", 1, exp_f);
        for (int c = 0; c < 32; c++) begin
            unequal_decim_enable = c[4];
            common_decim_factor = 4'(c);
            wr(OFS_DECIM_LOW, {4'(c), 4'(15 - c)});
            wr(OFS_DECIM_HIGH, {4'(15 - c), 4'(c)});
            step(2);
            for (int j = 0; j < 4; j++) begin
                e4 = (c[4] && (j == 0 || j == 3)) ? 4'(15 - c) : 4'(c);
                if (c[4]) note("uneq", j+5, 768'({e4, ratio(e4)}));
                else note("common", j+5, 768'({e4, ratio(e4)}));
                note("ratio", j+5, 768'({e4, ratio(e4)}));
            end
        end
        step(2);
        print_verdict();
    end
endmodule : ncoddc_ctrl_bench
